// ---- hw/pap_planner_top.sv ----
// Speed profile planner for one pulse-train axis, AXI4-Lite registers.
// Assumes a single 200 MHz clock and a synchronous active-low reset.
// Operation
// - Linear fixed-pulse moves find their own decel point, even with A != D.
// - Triangle prevention holds speed of linear (non S-curve) moves once accel plus decel pulses pass half.
// - Triangle prevention is off at reset; command 60h bit D3 enables it.
// - S-curve ramps acceleration up at jerk rate, holds, ramps down.
// - Symmetric S-curve starts reducing acceleration past one twelfth of P.
// - Manual decel mode never decelerates before the host-given point.
// - Mode bits D0 manual, D1 separate decel rate, D2 S-curve.
// - Command 03h loads the deceleration rate from the data register.
// - Pulse output stops when emitted pulses equal the commanded count.
`timescale 1ns/1ps
`default_nettype none
module pap_planner_top
  import pap_pkg::*;
(
  // Clock and reset
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // AXI4-Lite write
  input  wire logic [pap_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output var  logic                       s_axi_awready,
  input  wire logic [pap_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output var  logic                       s_axi_wready,
  output var  logic [1:0]                 s_axi_bresp,
  output var  logic                       s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  // AXI4-Lite read
  input  wire logic [pap_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output var  logic                       s_axi_arready,
  output var  logic [pap_pkg::DATA_W-1:0] s_axi_rdata,
  output var  logic [1:0]                 s_axi_rresp,
  output var  logic                       s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // Motor driver side
  output var  logic                       pulse_out,
  output var  logic                       drive_busy
);
  import pap_pkg::*;

  pap_pulse_if p ();
  pap_pulse_gen u_gen (.aclk(aclk), .aresetn(aresetn), .p(p.gen));

  logic [31:0] cfg [CFG_N];
  logic [31:0] next_cfg [CFG_N];
  logic [31:0] decel_rate, next_decel_rate;
  logic [31:0] ext_mode, next_ext_mode;
  logic        next_awready, next_arready, next_bvalid, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic        wr_take, cmd_start, cmd_stop;
  logic [3:0]  wix;
  logic [3:0]  rix;
  // Profile state, declared early: the read mux shows it
  pap_phase_t  phase, next_phase;
  logic [31:0] speed, next_speed, spd_frac, next_spd_frac;

  // Write accepted only once address and data are both offered
  assign wr_take = s_axi_awvalid && s_axi_awready;
  assign wix     = s_axi_awaddr[5:2];
  assign rix     = s_axi_araddr[5:2];

  // Register writes and commands
  always_comb
  begin
    next_cfg        = cfg;
    next_decel_rate = decel_rate;
    next_ext_mode   = ext_mode;
    next_bresp      = s_axi_bresp;
    cmd_start       = 1'b0;
    cmd_stop        = 1'b0;
    if (wr_take)
    begin
      next_bresp = RESP_OKAY;
      if (s_axi_awaddr[1:0] != 2'h0 || s_axi_awaddr[7:6] != 2'h0)
        next_bresp = RESP_SLVERR;
      else if (wix < 4'(CFG_N))
      begin
        for (int b = 0; b < 4; b++)
          if (s_axi_wstrb[b])
            next_cfg[wix][8*b +: 8] = s_axi_wdata[8*b +: 8];
        if (wix == IX_MODE)
          next_cfg[IX_MODE] = next_cfg[IX_MODE] & MODE_MASK;
      end
      else if (s_axi_awaddr == OFS_CMD && s_axi_wstrb[0])
      begin
        if (s_axi_wdata[7:0] == CMD_SET_DECEL)
          next_decel_rate = cfg[IX_DATA];
        else if (s_axi_wdata[7:0] == CMD_SET_EXT)
          next_ext_mode = cfg[IX_DATA];
        else if (s_axi_wdata[7:0] == CMD_START)
          cmd_start = 1'b1;
        else if (s_axi_wdata[7:0] == CMD_STOP)
          cmd_stop = 1'b1;
      end
      else if (s_axi_awaddr != OFS_CMD)
        next_bresp = RESP_SLVERR;
    end
  end

  // Handshake and read mux; readies pulse one cycle after valid
  always_comb
  begin
    next_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_awready
                   && !s_axi_bvalid;
    next_bvalid  = wr_take || (s_axi_bvalid && !s_axi_bready);
    next_arready = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
    next_rvalid  = (s_axi_arvalid && s_axi_arready)
                   || (s_axi_rvalid && !s_axi_rready);
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rresp = RESP_OKAY;
      next_rdata = RST_WORD;
      if (s_axi_araddr[1:0] != 2'h0 || s_axi_araddr[7:6] != 2'h0)
        next_rresp = RESP_SLVERR;
      else if (rix < 4'(CFG_N))
        next_rdata = cfg[rix];
      else if (s_axi_araddr == OFS_STATUS)
        next_rdata = {28'h0, phase};
      else if (s_axi_araddr == OFS_SPEED)
        next_rdata = speed;
      else if (s_axi_araddr == OFS_OUTCNT)
        next_rdata = p.count;
      else if (s_axi_araddr == OFS_DECEL)
        next_rdata = decel_rate;
      else if (s_axi_araddr == OFS_EXT)
        next_rdata = ext_mode;
      else if (s_axi_araddr != OFS_CMD)
        next_rresp = RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < CFG_N; i++)
        cfg[i] <= RST_WORD;
      decel_rate    <= RST_WORD;
      ext_mode      <= RST_EXT;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= RST_WORD;
    end
    else
    begin
      cfg           <= next_cfg;
      decel_rate    <= next_decel_rate;
      ext_mode      <= next_ext_mode;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_awready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rresp   <= next_rresp;
      s_axi_rdata   <= next_rdata;
    end
  end

  // Profile engine state
  logic [31:0] acc_cur, next_acc_cur, acc_frac, next_acc_frac;
  logic [31:0] gain, next_gain, pa, next_pa;
  logic        ramp, next_ramp, next_busy;
  logic        manual, sepdec, scurve, tri_en;
  logic [31:0] rem, s_rate, a_lim;
  logic [32:0] js, ss;
  logic [63:0] rem_d, pa_a;
  logic [65:0] tri_lhs, tri_rhs;
  logic        dec_start, tri_hit, twelfth;

  assign manual  = cfg[IX_MODE][MODE_MANUAL_BIT];
  assign sepdec  = cfg[IX_MODE][MODE_SEPDEC_BIT];
  assign scurve  = cfg[IX_MODE][MODE_SCURVE_BIT];
  assign tri_en  = ext_mode[EXT_TRI_BIT];
  assign rem     = cfg[IX_PCOUNT] - p.count;
  // Decel pulses scale as Pa*A/D; compare by products, no divider
  assign rem_d   = 64'(rem) * 64'(decel_rate);
  assign pa_a    = 64'(pa) * 64'(cfg[IX_ACCEL]);
  assign tri_lhs = (66'(pa) * (66'(cfg[IX_ACCEL]) + 66'(decel_rate))) << 1;
  assign tri_rhs = 66'(cfg[IX_PCOUNT]) * 66'(decel_rate);
  assign tri_hit = tri_en && !scurve && tri_lhs > tri_rhs;
  assign twelfth = 36'(pa) * 36'hC > 36'(cfg[IX_PCOUNT]);
  // Manual point counts pulses already emitted
  assign dec_start = manual ? (p.count >= cfg[IX_MANPT])
                   : scurve ? (rem <= pa) : (rem_d <= pa_a);
  // Rate of the jerk integrator in each phase
  assign s_rate  = (phase == PH_DEC && sepdec) ? cfg[IX_DECINC]
                 : cfg[IX_JERK];
  assign a_lim   = (phase == PH_DEC) ? decel_rate : cfg[IX_ACCEL];
  assign js      = 33'(acc_frac) + 33'(s_rate);
  assign ss      = 33'(spd_frac) + 33'(scurve ? acc_cur
                 : (phase == PH_DEC ? decel_rate : cfg[IX_ACCEL]));

  assign p.run    = (phase != PH_IDLE);
  assign p.clear  = cmd_start && phase == PH_IDLE;
  assign p.speed  = speed;
  assign p.target = cfg[IX_PCOUNT];
  assign pulse_out = p.pulse;

  // Profile next state; rates integrate one PPS per CLK_HZ of sum
  always_comb
  begin
    next_phase    = phase;
    next_speed    = speed;
    next_spd_frac = (ss >= 33'(CLK_HZ)) ? 32'(ss - 33'(CLK_HZ)) : ss[31:0];
    next_acc_frac = (js >= 33'(CLK_HZ)) ? 32'(js - 33'(CLK_HZ)) : js[31:0];
    next_acc_cur  = acc_cur;
    next_gain     = gain;
    next_pa       = pa;
    next_ramp     = ramp;
    case (phase)
      PH_IDLE:
      begin
        next_spd_frac = RST_WORD;
        next_acc_frac = RST_WORD;
        if (cmd_start)
        begin
          next_speed   = cfg[IX_INIT];
          next_acc_cur = RST_WORD;
          next_gain    = RST_WORD;
          next_pa      = RST_WORD;
          next_ramp    = 1'b0;
          next_phase   = (cfg[IX_DRIVE] > cfg[IX_INIT]) ? PH_ACC : PH_CONST;
        end
      end
      default:
      begin
        if (p.pulse && phase == PH_ACC)
          next_pa = pa + 32'h0000_0001;
        if (cmd_stop || p.count == cfg[IX_PCOUNT])
          next_phase = PH_IDLE;
        else if (phase != PH_DEC && dec_start)
        begin
          next_phase    = PH_DEC;
          next_acc_cur  = RST_WORD;
          next_acc_frac = RST_WORD;
          next_spd_frac = RST_WORD;
          next_gain     = RST_WORD;
          next_ramp     = 1'b0;
        end
        else if (phase != PH_CONST)
        begin
          // Acceleration value ramps, holds, ramps back to zero
          if (scurve)
          begin
            if (!ramp && js >= 33'(CLK_HZ) && acc_cur < a_lim)
              next_acc_cur = acc_cur + 32'h0000_0001;
            if (ramp && js >= 33'(CLK_HZ) && acc_cur != RST_WORD)
              next_acc_cur = acc_cur - 32'h0000_0001;
            if (!ramp && ss >= 33'(CLK_HZ))
              next_gain = gain + 32'h0000_0001;
            if (phase == PH_ACC && ((cfg[IX_DRIVE] - speed <= gain)
                || (!sepdec && twelfth)))
              next_ramp = 1'b1;
            if (phase == PH_DEC && speed - cfg[IX_INIT] <= gain)
              next_ramp = 1'b1;
            if (ramp && acc_cur == RST_WORD && phase == PH_ACC)
              next_phase = PH_CONST;
          end
          if (ss >= 33'(CLK_HZ) && phase == PH_ACC)
            next_speed = speed + 32'h0000_0001;
          if (ss >= 33'(CLK_HZ) && phase == PH_DEC && speed > cfg[IX_INIT])
            next_speed = speed - 32'h0000_0001;
          if (phase == PH_ACC && tri_hit)
            next_phase = PH_CONST;
          if (phase == PH_ACC && speed >= cfg[IX_DRIVE])
          begin
            next_speed = cfg[IX_DRIVE];
            next_phase = PH_CONST;
          end
        end
      end
    endcase
    next_busy = (next_phase != PH_IDLE);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      phase      <= PH_IDLE;
      speed      <= RST_WORD;
      spd_frac   <= RST_WORD;
      acc_cur    <= RST_WORD;
      acc_frac   <= RST_WORD;
      gain       <= RST_WORD;
      pa         <= RST_WORD;
      ramp       <= 1'b0;
      drive_busy <= 1'b0;
    end
    else
    begin
      phase      <= next_phase;
      speed      <= next_speed;
      spd_frac   <= next_spd_frac;
      acc_cur    <= next_acc_cur;
      acc_frac   <= next_acc_frac;
      gain       <= next_gain;
      pa         <= next_pa;
      ramp       <= next_ramp;
      drive_busy <= next_busy;
    end
  end

  // Checks on the profile and the register file
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_tri_reset_off: assert property ($past(!aresetn) |-> !tri_en)
    else $error("triangle prevention on after reset");
  a_ext_cmd_load: assert property (wr_take && s_axi_awaddr == OFS_CMD
    && s_axi_wstrb[0] && s_axi_wdata[7:0] == CMD_SET_EXT
    |=> ext_mode == $past(cfg[IX_DATA]))
    else $error("extension mode not loaded by 60h");
  a_decel_cmd_load: assert property (wr_take && s_axi_awaddr == OFS_CMD
    && s_axi_wstrb[0] && s_axi_wdata[7:0] == CMD_SET_DECEL
    |=> decel_rate == $past(cfg[IX_DATA]))
    else $error("decel rate not loaded by 03h");
  a_stop_at_count: assert property (phase != PH_IDLE
    && p.count == cfg[IX_PCOUNT] |=> phase == PH_IDLE ##1 !p.pulse)
    else $error("pulses continue past commanded count");
  a_speed_floor: assert property (phase == PH_DEC
    && $past(phase) == PH_DEC |-> speed >= cfg[IX_INIT])
    else $error("speed below initial speed");
  a_tri_hold: assert property (phase == PH_ACC && tri_hit
    && !dec_start && p.count != cfg[IX_PCOUNT] && !cmd_stop
    |=> phase == PH_CONST)
    else $error("acceleration kept past half the pulses");
  a_auto_decel: assert property (!manual && phase == PH_CONST
    && dec_start && p.count != cfg[IX_PCOUNT] && !cmd_stop
    |=> phase == PH_DEC)
    else $error("automatic decel point missed");
  a_manual_point: assert property (manual && phase == PH_DEC
    && $past(phase) != PH_DEC |-> $past(p.count) >= cfg[IX_MANPT])
    else $error("decel before manual point");
  a_twelfth_turn: assert property (scurve && !sepdec && phase == PH_ACC
    && !ramp && twelfth |=> ramp || phase != PH_ACC)
    else $error("accel not reduced past one twelfth");
  a_jerk_cap: assert property (scurve && phase == PH_ACC
    |-> acc_cur <= cfg[IX_ACCEL])
    else $error("acceleration beyond set value");
  a_write_resp: assert property (wr_take |=> s_axi_bvalid)
    else $error("write response missing");

  c_decel_reached: cover property (phase == PH_CONST ##1 phase == PH_DEC);
  c_tri_hold: cover property (phase == PH_ACC && tri_hit);
  c_scurve_ramp: cover property (scurve && $rose(ramp));
  c_bad_read: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule
`default_nettype wire

// ---- hw/pap_pkg.sv ----
// Constants and types for the single-axis speed profile planner.
// Assumes one 200 MHz clock; every rate below is counted on that clock.
package pap_pkg;
  // Clock and derived rate base (speeds in PPS, rates in PPS/s)
  localparam int          CLK_PERIOD_NS = 5;
  localparam logic [31:0] CLK_HZ        = 32'(1_000_000_000 / CLK_PERIOD_NS);
  // Bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_MODE   = 8'h00;
  localparam logic [7:0] OFS_DATA   = 8'h04;
  localparam logic [7:0] OFS_RANGE  = 8'h08;
  localparam logic [7:0] OFS_ACCEL  = 8'h0C;
  localparam logic [7:0] OFS_INIT   = 8'h10;
  localparam logic [7:0] OFS_DRIVE  = 8'h14;
  localparam logic [7:0] OFS_PCOUNT = 8'h18;
  localparam logic [7:0] OFS_JERK   = 8'h1C;
  localparam logic [7:0] OFS_DECINC = 8'h20;
  localparam logic [7:0] OFS_MANPT  = 8'h24;
  localparam logic [7:0] OFS_CMD    = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2C;
  localparam logic [7:0] OFS_SPEED  = 8'h30;
  localparam logic [7:0] OFS_OUTCNT = 8'h34;
  localparam logic [7:0] OFS_DECEL  = 8'h38;
  localparam logic [7:0] OFS_EXT    = 8'h3C;
  // Index of each writable config word except the range word at 08h
  localparam int CFG_N = 10;
  localparam logic [3:0] IX_MODE   = 4'h0;
  localparam logic [3:0] IX_DATA   = 4'h1;
  localparam logic [3:0] IX_ACCEL  = 4'h3;
  localparam logic [3:0] IX_INIT   = 4'h4;
  localparam logic [3:0] IX_DRIVE  = 4'h5;
  localparam logic [3:0] IX_PCOUNT = 4'h6;
  localparam logic [3:0] IX_JERK   = 4'h7;
  localparam logic [3:0] IX_DECINC = 4'h8;
  localparam logic [3:0] IX_MANPT  = 4'h9;
  // Field positions
  localparam int MODE_MANUAL_BIT = 0;
  localparam int MODE_SEPDEC_BIT = 1;
  localparam int MODE_SCURVE_BIT = 2;
  localparam int EXT_TRI_BIT     = 3;
  localparam logic [31:0] MODE_MASK = 32'h0000_0007;
  // Command codes
  localparam logic [7:0] CMD_SET_DECEL = 8'h03;
  localparam logic [7:0] CMD_SET_EXT   = 8'h60;
  localparam logic [7:0] CMD_START     = 8'h20;
  localparam logic [7:0] CMD_STOP      = 8'h27;
  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [31:0] RST_EXT  = 32'h0000_0000;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Profile phases
  typedef enum logic [3:0] {
    PH_IDLE  = 4'h1,
    PH_ACC   = 4'h2,
    PH_CONST = 4'h4,
    PH_DEC   = 4'h8
  } pap_phase_t;
endpackage

// ---- hw/pap_pulse_if.sv ----
// Link between the profile engine and the pulse generator.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface pap_pulse_if;
  logic        run;
  logic        clear;
  logic [31:0] speed;
  logic [31:0] target;
  logic        pulse;
  logic [31:0] count;
  modport gen (input run, input clear, input speed, input target,
               output pulse, output count);
  modport ctl (output run, output clear, output speed, output target,
               input pulse, input count);
endinterface
`default_nettype wire

// ---- hw/pap_pulse_gen.sv ----
// Pulse generator: phase accumulator turning a PPS value into pulses.
// Assumes speed stays below the clock rate.
`timescale 1ns/1ps
`default_nettype none
module pap_pulse_gen
  import pap_pkg::*;
(
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Engine side
  pap_pulse_if.gen  p
);
  logic [31:0] acc;
  logic [31:0] next_acc;
  logic [31:0] next_count;
  logic        next_pulse;
  logic [32:0] sum;

  // Accumulate speed; one pulse per CLK_HZ of phase
  always_comb
  begin
    next_acc   = acc;
    next_count = p.count;
    next_pulse = 1'b0;
    sum        = 33'(acc) + 33'(p.speed);
    if (p.clear)
    begin
      next_acc   = RST_WORD;
      next_count = RST_WORD;
    end
    else if (p.run && p.count != p.target)
    begin
      if (sum >= 33'(CLK_HZ))
      begin
        next_acc   = 32'(sum - 33'(CLK_HZ));
        next_pulse = 1'b1;
        next_count = p.count + 32'h0000_0001;
      end
      else
        next_acc = sum[31:0];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      acc     <= RST_WORD;
      p.count <= RST_WORD;
      p.pulse <= 1'b0;
    end
    else
    begin
      acc     <= next_acc;
      p.count <= next_count;
      p.pulse <= next_pulse;
    end
  end
endmodule
`default_nettype wire

// ---- tb/pap_motor_model.sv ----
// Motor driver model: counts the step pulses that the planner emits.
// Assumes one step per high cycle of the pulse line, on the planner clock.
`timescale 1ns/1ps
`default_nettype none
module pap_motor_model
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Step input and count
  input  wire logic        step_in,
  input  wire logic        clr,
  output var  logic [31:0] steps
);
  logic [31:0] next_steps;
  // Each high cycle is one step; a real driver latches every pulse
  always_comb
  begin
    next_steps = steps;
    if (clr)
      next_steps = 32'h0000_0000;
    else if (step_in)
      next_steps = steps + 32'h0000_0001;
  end
  // Register the step count
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      steps <= 32'h0000_0000;
    else
      steps <= next_steps;
  end
endmodule
`default_nettype wire

// ---- tb/pulse_accel_profile_planner_tb_top.sv ----
// Self-checking bench for the planner: register access and fixed moves.
// Assumes the planner top on AXI4-Lite and the motor model on its pulses.
`timescale 1ns/1ps
`default_nettype none
module pulse_accel_profile_planner_tb_top;
  import pap_pkg::*;
  localparam logic [31:0] R_LO = 32'h05F5_E100;
  localparam logic [31:0] R_HI = 32'h08F0_D180;
  localparam logic [31:0] V_SV = 32'h0098_9680;
  // Drive speed 600 PPS above initial so the 200-pulse moves reach a flat top
  localparam logic [31:0] V_DR = 32'h0098_98D8;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        steps_clr = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        pulse_out, drive_busy;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, steps, d, dec_at, vmin, vmax;
  logic [3:0]  seen;
  int          fail_count = 0;
  int          samples_checked = 0;

  // 200 MHz clock
  always #2.5 aclk = ~aclk;

  pap_planner_top i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pulse_out(pulse_out),
    .drive_busy(drive_busy));

  pap_motor_model i_motor (
    .aclk(aclk), .aresetn(aresetn), .step_in(pulse_out),
    .clr(steps_clr), .steps(steps));

  // Verdict and end of run
  task automatic conclude();
    $display("Compared %0d, mismatched %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  // Write: address and data offered together, held until taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] er);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", 32'(er), 32'(bresp));
  endtask

  // Read: data and response taken at the rvalid edge
  task automatic rd(input logic [7:0] a, input logic [1:0] er,
                    output logic [31:0] v);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    v = rdata;
    chk("rresp", 32'(er), 32'(rresp));
  endtask

  // Parameters for one move; decel rate goes in through command 03h
  task automatic cfg(input logic [31:0] m, input logic [31:0] a,
                     input logic [31:0] dr, input logic [31:0] p);
    wr(OFS_MODE, m, RESP_OKAY);
    wr(OFS_RANGE, 32'h0000_1F40, RESP_OKAY);
    wr(OFS_ACCEL, a, RESP_OKAY);
    wr(OFS_DATA, dr, RESP_OKAY);
    wr(OFS_CMD, 32'(CMD_SET_DECEL), RESP_OKAY);
    wr(OFS_INIT, V_SV, RESP_OKAY);
    wr(OFS_DRIVE, V_DR, RESP_OKAY);
    wr(OFS_PCOUNT, p, RESP_OKAY);
  endtask

  // Start, poll speed, phase and count until idle, then check totals
  task automatic move(input logic [31:0] p);
    logic [31:0] st, v, c;
    seen = 4'h0;
    dec_at = 32'hFFFF_FFFF;
    vmin = 32'hFFFF_FFFF;
    vmax = 32'h0000_0000;
    st = 32'h0000_0000;
    steps_clr <= 1'b1;
    @(posedge aclk);
    steps_clr <= 1'b0;
    wr(OFS_CMD, 32'(CMD_START), RESP_OKAY);
    chk("busy at start", 32'h1, 32'(drive_busy));
    while (st !== 32'(PH_IDLE))
    begin
      rd(OFS_SPEED, RESP_OKAY, v);
      rd(OFS_STATUS, RESP_OKAY, st);
      rd(OFS_OUTCNT, RESP_OKAY, c);
      seen = seen | st[3:0];
      if (st === 32'(PH_DEC) && c < dec_at)
        dec_at = c;
      if (st !== 32'(PH_IDLE) && v < vmin)
        vmin = v;
      if (st !== 32'(PH_IDLE) && v > vmax)
        vmax = v;
    end
    // Idle line must stay quiet after the last step
    repeat (50) @(posedge aclk);
    chk("motor steps", p, steps);
    rd(OFS_OUTCNT, RESP_OKAY, c);
    chk("out count", p, c);
    chk("busy", 32'h0, 32'(drive_busy));
    chk("min speed", 32'h1, 32'(vmin >= V_SV));
    chk("max speed", 32'h1, 32'(vmax <= V_DR));
  endtask

  // Hang guard, well beyond the expected run length
  initial
  begin
    repeat (90000) @(posedge aclk);
    fail_count++;
    conclude();
  end

  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Reset values and refused accesses
    rd(OFS_EXT, RESP_OKAY, d);
    chk("ext at reset", RST_EXT, d);
    rd(OFS_STATUS, RESP_OKAY, d);
    chk("phase at reset", 32'(PH_IDLE), d);
    rd(8'h40, RESP_SLVERR, d);
    wr(OFS_STATUS, 32'h0000_0001, RESP_SLVERR);
    wr(OFS_MODE, 32'hFFFF_FFFF, RESP_OKAY);
    rd(OFS_MODE, RESP_OKAY, d);
    chk("mode bits", MODE_MASK, d);
    wr(OFS_DATA, R_HI, RESP_OKAY);
    wr(OFS_CMD, 32'(CMD_SET_DECEL), RESP_OKAY);
    rd(OFS_DECEL, RESP_OKAY, d);
    chk("decel rate", R_HI, d);
    // Asymmetric linear moves, A below D then A above D
    cfg(32'h0, R_LO, R_HI, 32'h0000_00C8);
    move(32'h0000_00C8);
    chk("phases A<D", 32'hF, 32'(seen));
    cfg(32'h0, R_HI, R_LO, 32'h0000_00C8);
    move(32'h0000_00C8);
    chk("phases A>D", 32'hF, 32'(seen));
    // Short move: triangle without prevention, flat top with it
    cfg(32'h0, R_LO, R_LO, 32'h0000_003C);
    move(32'h0000_003C);
    chk("const w/o prev", 32'h0, 32'(seen[2]));
    wr(OFS_DATA, 32'h0000_0008, RESP_OKAY);
    wr(OFS_CMD, 32'(CMD_SET_EXT), RESP_OKAY);
    rd(OFS_EXT, RESP_OKAY, d);
    chk("ext enabled", 32'h0000_0008, d);
    move(32'h0000_003C);
    chk("const w/ prev", 32'h1, 32'(seen[2]));
    chk("capped speed", 32'h1, 32'(vmax < V_DR));
    wr(OFS_DATA, 32'h0000_0000, RESP_OKAY);
    wr(OFS_CMD, 32'(CMD_SET_EXT), RESP_OKAY);
    // Symmetric S-curve
    cfg(32'h4, R_LO, R_LO, 32'h0000_0078);
    wr(OFS_JERK, R_HI, RESP_OKAY);
    move(32'h0000_0078);
    chk("S phases", 32'hA, 32'(seen & 4'hA));
    // Asymmetric S-curve, decel only from the host point
    cfg(32'h7, R_LO, R_LO, 32'h0000_0078);
    wr(OFS_DECINC, R_LO, RESP_OKAY);
    wr(OFS_MANPT, 32'h0000_0050, RESP_OKAY);
    move(32'h0000_0078);
    chk("manual point", 32'h1, 32'(dec_at >= 32'h50));
    chk("manual decel", 32'h8, 32'(seen & 4'h8));
    conclude();
  end
endmodule
`default_nettype wire
